// ==== dv/dpch_pulse_src.sv ====
`timescale 1ns/1ps
module dpch_pulse_src (
    // Clock.
    input wire logic hclk,
    // Sensor pulse lines and hold line.
    output logic meter_a,
    output logic meter_b,
    output logic hold_line
);
    initial begin
        meter_a = 1'h0;
        meter_b = 1'h0;
        hold_line = 1'h0;
    end

    // Push-pull sensor: clean edges only, since a bouncing contact would add counts.
    task automatic pulse(input logic on_a, input logic on_b, input int width);
        @(posedge hclk);
        meter_a <= on_a;
        meter_b <= on_b;
        repeat (width) @(posedge hclk);
        meter_a <= 1'h0;
        meter_b <= 1'h0;
        repeat (4) @(posedge hclk);
    endtask : pulse

    // Outside equipment frames a counting window with the hold line.
    task automatic set_hold(input logic level);
        @(posedge hclk);
        hold_line <= level;
    endtask : set_hold
endmodule : dpch_pulse_src

// ==== dv/dual_pulse_counter_hold_tb.sv ====
`timescale 1ns/1ps
module dual_pulse_counter_hold_tb;
    import dpch_pkg::*;
    localparam int unsigned MIN = 8;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, reset_key, select_key;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic meter_a, meter_b, hold_line, copy_a, copy_b, copy_a_q, copy_b_q, display_chan;
    logic [27:0] display_count;
    int fails = 0;
    int samples_checked = 0;
    int rises_a = 0;
    int rises_b = 0;

    dpch_top #(.MIN_PULSE_CYC(MIN)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .first_meter_input(meter_a), .second_meter_input(meter_b), .hold_in(hold_line),
        .first_meter_copy(copy_a), .second_meter_copy(copy_b), .reset_key(reset_key),
        .select_key(select_key), .display_count(display_count), .display_chan(display_chan));

    dpch_pulse_src src (.hclk(hclk), .meter_a(meter_a), .meter_b(meter_b),
        .hold_line(hold_line));

    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end

    // Rising edges of the pulse copies, to compare against accepted pulses.
    always @(posedge hclk) begin
        copy_a_q <= copy_a;
        copy_b_q <= copy_b;
        if (copy_a === 1'h1 && copy_a_q === 1'h0) rises_a <= rises_a + 1;
        if (copy_b === 1'h1 && copy_b_q === 1'h0) rises_b <= rises_b + 1;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // One single word transfer; only the watchdog ends a wait that never gets its answer.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        hsel <= 1'h1;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "response not OKAY");
    endtask : ahb

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        ahb(1'h0, {24'h0, ofs}, 32'h0, d);
        check(d, exp, msg);
    endtask : rd_chk

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'h1, {24'h0, ofs}, d, unused);
    endtask : wr

    task automatic press(input logic right_key);
        @(posedge hclk);
        if (right_key) reset_key <= 1'h1;
        else select_key <= 1'h1;
        repeat (2) @(posedge hclk);
        reset_key <= 1'h0;
        select_key <= 1'h0;
        repeat (4) @(posedge hclk);
    endtask : press

    initial begin
        #100000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        reset_key = 1'h0;
        select_key = 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        // All registers and the unmapped word after them read zero.
        for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0, "reset value");
        // A pulse that is too short is dropped; long ones count on the first channel, and every other one also on the second.
        src.pulse(1'h1, 1'h1, MIN - 1);
        for (int i = 0; i < 4; i++) src.pulse(1'h1, i % 2 == 0, MIN + 2);
        rd_chk(CNTA_OFS, 32'h4, "first count");
        rd_chk(CNTB_OFS, 32'h2, "second count");
        check(rises_a, 32'h4, "first copies");
        check(rises_b, 32'h2, "second copies");
        // Frozen while the hold line is high, resumed from the held values.
        src.set_hold(1'h1);
        src.pulse(1'h1, 1'h1, MIN + 2);
        rd_chk(STAT_OFS, 32'h2, "hold status");
        rd_chk(CNTA_OFS, 32'h4, "first held");
        src.set_hold(1'h0);
        src.pulse(1'h1, 1'h1, MIN + 2);
        rd_chk(CNTA_OFS, 32'h5, "first resumed");
        rd_chk(CNTB_OFS, 32'h3, "second resumed");
        wr(CTRL_OFS, 32'h4);
        src.pulse(1'h1, 1'h0, MIN + 2);
        rd_chk(CNTA_OFS, 32'h5, "software hold");
        wr(CTRL_OFS, 32'h0);
        // Display channel selection by key and by register.
        press(1'h0);
        check({31'h0, display_chan}, 32'h1, "display channel");
        check({4'h0, display_count}, 32'h3, "display count");
        rd_chk(STAT_OFS, 32'h1, "selected status");
        rd_chk(DISP_OFS, 32'h80000003, "display register");
        wr(CTRL_OFS, 32'h2);
        repeat (4) @(posedge hclk);
        check({31'h0, display_chan}, 32'h0, "display back");
        check({4'h0, display_count}, 32'h5, "display first");
        // Clear by key, then again by register after fresh counts.
        press(1'h1);
        rd_chk(CNTA_OFS, 32'h0, "first cleared");
        rd_chk(CNTB_OFS, 32'h0, "second cleared");
        src.pulse(1'h1, 1'h1, MIN + 2);
        rd_chk(CNTB_OFS, 32'h1, "count after clear");
        wr(CTRL_OFS, 32'h1);
        repeat (4) @(posedge hclk);
        rd_chk(CNTA_OFS, 32'h0, "first cleared by register");
        rd_chk(CNTB_OFS, 32'h0, "second cleared by register");
        summarize();
    end
endmodule : dual_pulse_counter_hold_tb

// ==== logic/dpch_pulse_chan.sv ====
`timescale 1ns/1ps
module dpch_pulse_chan #(
    parameter int unsigned MIN_CYC = dpch_pkg::PULSE_MIN_CYC
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Control.
    input wire logic pulse_in,
    input wire logic hold,
    input wire logic clear,
    // State.
    output dpch_pkg::dpch_chan_t chan_o
);
    import dpch_pkg::*;

    localparam int unsigned WW = $clog2(MIN_CYC + 2);
    localparam logic [WW-1:0] MIN_W = WW'(MIN_CYC);

    logic [WW-1:0] width_reg, width_next;
    logic [CNT_W-1:0] count_reg, count_next, inc_val;
    logic copy_reg, copy_next, ovf_reg, ovf_next;
    logic accept;
    logic [DIGITS:0] carry;

    assign carry[0] = 1'b1;

    genvar g;
    for (g = 0; g < DIGITS; g++) begin : g_digit
        logic [3:0] d;
        assign d = count_reg[4*g +: 4];
        assign inc_val[4*g +: 4] = !carry[g] ? d : ((d == DIGIT_MAX) ? 4'h0 : d + 4'h1);
        assign carry[g+1] = carry[g] && (d == DIGIT_MAX);
        digit_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
            d <= DIGIT_MAX) else $error("Counter digit left the decimal range.");
    end

    always_comb begin
        width_next = width_reg;
        if (!pulse_in) begin
            width_next = '0;
        end else if (width_reg != MIN_W + 1'b1) begin
            width_next = width_reg + 1'b1;
        end
        // A pulse counts once it has stood high for more than the minimum width.
        accept = pulse_in && (width_reg == MIN_W);
        copy_next = copy_reg;
        if (accept) begin
            copy_next = 1'b1;
        end else if (!pulse_in) begin
            copy_next = 1'b0;
        end
        count_next = count_reg;
        ovf_next = 1'b0;
        if (clear) begin
            count_next = '0;
        end else if (accept && !hold) begin
            count_next = inc_val;
            ovf_next = carry[DIGITS];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            width_reg <= '0;
            count_reg <= '0;
            copy_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            width_reg <= width_next;
            count_reg <= count_next;
            copy_reg <= copy_next;
            ovf_reg <= ovf_next;
        end
    end

    assign chan_o = '{count: count_reg, overflow: ovf_reg, copy: copy_reg};

    min_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept |-> $past(pulse_in) && width_reg == MIN_W)
        else $error("Pulse accepted before the minimum width.");
    count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hold && !clear |=> $stable(count_reg)) else $error("Counter moved while held.");
    count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && !hold && !clear |=> count_reg == $past(inc_val) && count_reg != $past(count_reg))
        else $error("Accepted pulse did not step the counter.");
    count_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && !hold && !clear && count_reg == CNT_MAX |=> count_reg == '0 && ovf_reg)
        else $error("Counter did not wrap to zero with overflow.");
    copy_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept |=> copy_reg ##0 (copy_reg throughout (pulse_in [*1])) or !pulse_in)
        else $error("Pulse copy did not follow the accepted pulse.");

endmodule : dpch_pulse_chan

// ==== logic/dpch_top.sv ====
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module dpch_top #(
    parameter int unsigned MIN_PULSE_CYC = dpch_pkg::PULSE_MIN_CYC
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Meter inputs, hold input and pulse copies.
    input wire logic first_meter_input,
    input wire logic second_meter_input,
    input wire logic hold_in,
    output logic first_meter_copy,
    output logic second_meter_copy,
    // Front panel.
    input wire logic reset_key,
    input wire logic select_key,
    output logic [27:0] display_count,
    output logic display_chan
);
    import dpch_pkg::*;

    dpch_chan_t chan_a, chan_b;

    // Bus state.
    dpch_bus_t bus_reg, bus_next;
    logic [7:0] addr_reg, addr_next;
    logic wr_reg, wr_next;
    logic ok_reg, ok_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic sw_hold_reg, sw_hold_next;
    logic sw_clr_reg, sw_clr_next;
    logic sw_sel_reg, sw_sel_next;
    logic ovf_a_reg, ovf_a_next;
    logic ovf_b_reg, ovf_b_next;
    logic take;

    // Panel and channel control state.
    logic rkey_reg, skey_reg;
    logic sel_reg, sel_next;
    logic hold_reg, hold_next;
    logic clear_reg, clear_next;
    logic copy_a_reg, copy_b_reg;
    logic [27:0] disp_reg, disp_next;
    logic disp_chan_reg;
    logic rpress, spress;

    dpch_pulse_chan #(.MIN_CYC(MIN_PULSE_CYC)) u_chan_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .pulse_in(first_meter_input),
        .hold(hold_reg),
        .clear(clear_reg),
        .chan_o(chan_a)
    );

    dpch_pulse_chan #(.MIN_CYC(MIN_PULSE_CYC)) u_chan_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .pulse_in(second_meter_input),
        .hold(hold_reg),
        .clear(clear_reg),
        .chan_o(chan_b)
    );

    // The slave inserts one wait state so that read data comes from a flop.
    always_comb begin
        take = hsel && hready && htrans[1];
        bus_next = bus_reg;
        addr_next = addr_reg;
        wr_next = wr_reg;
        ok_next = ok_reg;
        rdata_next = rdata_reg;
        ready_next = ready_reg;
        sw_hold_next = sw_hold_reg;
        sw_clr_next = 1'b0;
        sw_sel_next = 1'b0;
        ovf_a_next = ovf_a_reg;
        ovf_b_next = ovf_b_reg;
        unique case (bus_reg)
            BUS_IDLE: begin
                if (take) begin
                    addr_next = haddr[7:0];
                    wr_next = hwrite;
                    ok_next = (haddr[31:8] == 24'h000000) && (hsize == HSIZE_WORD);
                    ready_next = 1'b0;
                    bus_next = BUS_DATA;
                end
            end
            BUS_DATA: begin
                ready_next = 1'b1;
                bus_next = BUS_IDLE;
                rdata_next = 32'h00000000;
                if (ok_reg && wr_reg) begin
                    unique case (addr_reg)
                        CTRL_OFS: begin
                            sw_clr_next = hwdata[CTRL_CLR_BIT];
                            sw_sel_next = hwdata[CTRL_SEL_BIT];
                            sw_hold_next = hwdata[CTRL_HOLD_BIT];
                        end
                        STAT_OFS: begin
                            ovf_a_next = ovf_a_reg & ~hwdata[STAT_OVFA_BIT];
                            ovf_b_next = ovf_b_reg & ~hwdata[STAT_OVFB_BIT];
                        end
                        default: begin
                        end
                    endcase
                end else if (ok_reg) begin
                    unique case (addr_reg)
                        CTRL_OFS: rdata_next[CTRL_HOLD_BIT] = sw_hold_reg;
                        STAT_OFS: begin
                            rdata_next[STAT_SEL_BIT] = sel_reg;
                            rdata_next[STAT_HOLD_BIT] = hold_reg;
                            rdata_next[STAT_OVFA_BIT] = ovf_a_reg;
                            rdata_next[STAT_OVFB_BIT] = ovf_b_reg;
                        end
                        CNTA_OFS: rdata_next[27:0] = chan_a.count;
                        CNTB_OFS: rdata_next[27:0] = chan_b.count;
                        DISP_OFS: begin
                            rdata_next[27:0] = disp_reg;
                            rdata_next[DISP_CHAN_BIT] = disp_chan_reg;
                        end
                        default: rdata_next = 32'h00000000;
                    endcase
                end
            end
        endcase
        // A wrap in the same cycle as a clearing write still leaves the flag set.
        if (chan_a.overflow) begin
            ovf_a_next = 1'b1;
        end
        if (chan_b.overflow) begin
            ovf_b_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg <= BUS_IDLE;
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            ok_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b1;
            sw_hold_reg <= SW_HOLD_RST;
            sw_clr_reg <= 1'b0;
            sw_sel_reg <= 1'b0;
            ovf_a_reg <= 1'b0;
            ovf_b_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            addr_reg <= addr_next;
            wr_reg <= wr_next;
            ok_reg <= ok_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            sw_hold_reg <= sw_hold_next;
            sw_clr_reg <= sw_clr_next;
            sw_sel_reg <= sw_sel_next;
            ovf_a_reg <= ovf_a_next;
            ovf_b_reg <= ovf_b_next;
        end
    end

    // Keys are taken as clean levels; a press is the rising edge.
    always_comb begin
        rpress = reset_key && !rkey_reg;
        spress = select_key && !skey_reg;
        // A low or unconnected hold input lets counting go on while the software hold bit is clear.
        hold_next = hold_in || sw_hold_reg;
        clear_next = rpress || sw_clr_reg;
        sel_next = sel_reg ^ (spress || sw_sel_reg);
        disp_next = sel_reg ? chan_b.count : chan_a.count;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rkey_reg <= 1'b0;
            skey_reg <= 1'b0;
            sel_reg <= SEL_RST;
            hold_reg <= 1'b0;
            clear_reg <= 1'b0;
            copy_a_reg <= 1'b0;
            copy_b_reg <= 1'b0;
            disp_reg <= 28'h0000000;
            disp_chan_reg <= SEL_RST;
        end else begin
            rkey_reg <= reset_key;
            skey_reg <= select_key;
            sel_reg <= sel_next;
            hold_reg <= hold_next;
            clear_reg <= clear_next;
            copy_a_reg <= chan_a.copy;
            copy_b_reg <= chan_b.copy;
            disp_reg <= disp_next;
            disp_chan_reg <= sel_reg;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;
    assign first_meter_copy = copy_a_reg;
    assign second_meter_copy = copy_b_reg;
    assign display_count = disp_reg;
    assign display_chan = disp_chan_reg;

    clear_both_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rpress |=> ##1 chan_a.count == 28'h0000000 && chan_b.count == 28'h0000000)
        else $error("Reset key did not clear both counters.");
    select_flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        spress && !sw_sel_reg |=> ##1 display_chan != $past(sel_reg, 2))
        else $error("Select key did not switch the shown channel.");
    display_show_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 display_count == ($past(sel_reg) ? $past(chan_b.count) : $past(chan_a.count)))
        else $error("Display does not show the selected count.");
    open_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hold_in && !sw_hold_reg |=> !hold_reg) else $error("Idle hold input stopped counting.");
    hold_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hold_in [*3] |-> $stable(chan_a.count) || $past(clear_reg))
        else $error("Counter moved under a held input.");
    copy_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(chan_a.copy) |=> first_meter_copy ##0 $past(first_meter_input, 2))
        else $error("First pulse copy missing.");
    bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && bus_reg == BUS_IDLE |=> !hreadyout ##1 hreadyout)
        else $error("Bus answer not after exactly one wait state.");
    ovf_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        chan_b.overflow |=> ovf_b_reg) else $error("Overflow flag lost its set.");

endmodule : dpch_top

// ==== shared/dpch_pkg.sv ====
package dpch_pkg;

    // Clock and the pulse width that a counted pulse must exceed.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PULSE_MIN_NS = 1_000_000;
    localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Seven decimal digits per channel.
    localparam int unsigned DIGITS = 7;
    localparam int unsigned CNT_W = 4 * DIGITS;
    localparam logic [27:0] CNT_MAX = 28'h9999999;
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CNTA_OFS = 8'h08;
    localparam logic [7:0] CNTB_OFS = 8'h0C;
    localparam logic [7:0] DISP_OFS = 8'h10;

    // Field positions.
    localparam int unsigned CTRL_CLR_BIT = 0;
    localparam int unsigned CTRL_SEL_BIT = 1;
    localparam int unsigned CTRL_HOLD_BIT = 2;
    localparam int unsigned STAT_SEL_BIT = 0;
    localparam int unsigned STAT_HOLD_BIT = 1;
    localparam int unsigned STAT_OVFA_BIT = 2;
    localparam int unsigned STAT_OVFB_BIT = 3;
    localparam int unsigned DISP_CHAN_BIT = 31;

    // Values after reset, and the word transfer size.
    localparam logic SEL_RST = 1'b0;
    localparam logic SW_HOLD_RST = 1'b0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [27:0] count;
        logic overflow;
        logic copy;
    } dpch_chan_t;

    typedef enum {BUS_IDLE, BUS_DATA} dpch_bus_t;

endpackage : dpch_pkg
